/* adcc_top.sv */
// Converter control, status, trigger and result read logic
`timescale 1ns/10ps
`default_nettype none
module adcc_top (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       standby,
  input  wire logic [3:0] bus_addr,
  input  wire logic       bus_rd,
  input  wire logic       bus_wr,
  input  wire logic [7:0] bus_wdata,
  output logic      [7:0] bus_rdata,
  output logic            bus_rvalid,
  input  wire logic       multi_timer_unit_trig,
  output logic            conv_req,
  output logic      [2:0] conv_chan,
  output logic            conv_fast,
  input  wire logic       conv_done,
  input  wire logic [9:0] conv_data,
  output logic            conv_end_irq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic                 conv_end_flag_r;
  logic                 conv_end_flag_nxt;
  logic                 conv_irq_enable_r;
  logic                 conv_go_r;
  logic                 conv_go_nxt;
  logic                 scan_mode_r;
  logic                 conv_speed_select_r;
  logic [2:0]           chan_sel_r;
  logic                 timer_trigger_enable_r;
  logic                 flag_seen_r;
  logic                 flag_seen_nxt;
  logic                 trig_prev_r;
  adcc_pkg::adcc_state_t state_r;
  logic [1:0]           pos_r;
  logic [8:0]           slot_r;
  logic                 req_r;
  logic [2:0]           chan_r;
  logic                 irq_r;
  logic                 rd_p1_r;
  logic [3:0]           rd_addr_p1_r;
  logic [7:0]           rdata_r;
  logic                 rvalid_r;
  logic [7:0]           temp_r;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire       wr_csr      = bus_wr && (bus_addr == adcc_pkg::OFF_CSR);
  wire       wr_trg      = bus_wr && (bus_addr == adcc_pkg::OFF_TRG);
  wire       rd_res      = bus_rd && !bus_addr[3];
  wire [1:0] rd_res_idx  = bus_addr[2:1];
  wire       p1_res      = rd_p1_r && !rd_addr_p1_r[3];
  wire       p1_res_hi   = p1_res && !rd_addr_p1_r[0];
  wire       p1_res_lo   = p1_res && rd_addr_p1_r[0];
  wire       p1_csr      = rd_p1_r && (rd_addr_p1_r == adcc_pkg::OFF_CSR);
  wire       p1_trg      = rd_p1_r && (rd_addr_p1_r == adcc_pkg::OFF_TRG);
  wire [9:0] mem_q;

  // ------------------------------------------------------------
  // Channel sequencing
  // ------------------------------------------------------------
  wire [1:0] scan_last   = chan_sel_r[1:0];
  wire [2:0] chan_scan   = {chan_sel_r[2], pos_r};
  wire [2:0] chan_cur    = scan_mode_r ? chan_scan : chan_sel_r;
  wire [1:0] res_idx     = scan_mode_r ? pos_r : chan_sel_r[1:0];
  wire       in_conv     = (state_r == adcc_pkg::ADCC_CONV);
  wire       slot_out    = (slot_r == 9'h000);
  wire       conv_end    = in_conv && conv_go_r && (conv_done || slot_out);
  wire       pos_last    = (pos_r == scan_last);
  wire       round_end   = conv_end && (!scan_mode_r || pos_last);
  wire       single_end  = round_end && !scan_mode_r;
  wire [8:0] slot_load   = conv_speed_select_r ? adcc_pkg::SLOT_FAST_LOAD
                                               : adcc_pkg::SLOT_SLOW_LOAD;

  // ------------------------------------------------------------
  // Start, stop and trigger
  // ------------------------------------------------------------
  wire trig_edge = multi_timer_unit_trig && !trig_prev_r;
  wire trig_hit  = timer_trigger_enable_r && trig_edge;
  wire sw_go     = wr_csr && bus_wdata[adcc_pkg::CSR_GO_BIT];
  wire go_set    = sw_go || trig_hit;
  wire go_clr    = wr_csr || single_end;

  always_comb
  begin
    conv_go_nxt = conv_go_r;
    if (go_set)
    begin
      conv_go_nxt = 1'b1;
    end
    else if (go_clr)
    begin
      conv_go_nxt = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // End flag: set wins over a clear in the same cycle
  // ------------------------------------------------------------
  wire flag_wr0  = wr_csr && !bus_wdata[adcc_pkg::CSR_FLAG_BIT];
  wire flag_clr  = flag_wr0 && flag_seen_r && conv_end_flag_r;

  always_comb
  begin
    conv_end_flag_nxt = conv_end_flag_r;
    flag_seen_nxt     = flag_seen_r;
    if (round_end)
    begin
      conv_end_flag_nxt = 1'b1;
    end
    else if (flag_clr)
    begin
      conv_end_flag_nxt = 1'b0;
    end
    if (flag_clr)
    begin
      flag_seen_nxt = 1'b0;
    end
    else if (p1_csr && conv_end_flag_r)
    begin
      flag_seen_nxt = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Control/status register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      conv_end_flag_r     <= adcc_pkg::CSR_RESET[adcc_pkg::CSR_FLAG_BIT];
      conv_irq_enable_r   <= adcc_pkg::CSR_RESET[adcc_pkg::CSR_IE_BIT];
      conv_go_r           <= adcc_pkg::CSR_RESET[adcc_pkg::CSR_GO_BIT];
      scan_mode_r         <= adcc_pkg::CSR_RESET[adcc_pkg::CSR_SCAN_BIT];
      conv_speed_select_r <= adcc_pkg::CSR_RESET[adcc_pkg::CSR_SPEED_BIT];
      chan_sel_r          <= adcc_pkg::CSR_RESET[2:0];
      flag_seen_r         <= 1'b0;
    end
    else
    begin
      conv_end_flag_r <= conv_end_flag_nxt;
      conv_go_r       <= conv_go_nxt;
      flag_seen_r     <= flag_seen_nxt;
      if (wr_csr)
      begin
        conv_irq_enable_r   <= bus_wdata[adcc_pkg::CSR_IE_BIT];
        scan_mode_r         <= bus_wdata[adcc_pkg::CSR_SCAN_BIT];
        conv_speed_select_r <= bus_wdata[adcc_pkg::CSR_SPEED_BIT];
        chan_sel_r          <= bus_wdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Trigger control register and trigger edge
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_trigger_enable_r <= adcc_pkg::TRG_RESET[adcc_pkg::TRG_EN_BIT];
      trig_prev_r            <= 1'b0;
    end
    else
    begin
      trig_prev_r <= multi_timer_unit_trig;
      if (standby)
      begin
        timer_trigger_enable_r <= adcc_pkg::TRG_RESET[adcc_pkg::TRG_EN_BIT];
      end
      else if (wr_trg)
      begin
        timer_trigger_enable_r <= bus_wdata[adcc_pkg::TRG_EN_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= adcc_pkg::ADCC_IDLE;
      pos_r   <= 2'h0;
      slot_r  <= 9'h000;
      req_r   <= 1'b0;
      chan_r  <= 3'h0;
    end
    else
    begin
      case (state_r)
        adcc_pkg::ADCC_IDLE:
        begin
          if (conv_go_r)
          begin
            state_r <= adcc_pkg::ADCC_CONV;
            req_r   <= 1'b1;
            chan_r  <= chan_cur;
            slot_r  <= slot_load;
          end
          else
          begin
            pos_r <= 2'h0;
          end
        end
        adcc_pkg::ADCC_CONV:
        begin
          if (!conv_go_r)
          begin
            state_r <= adcc_pkg::ADCC_IDLE;
            req_r   <= 1'b0;
            pos_r   <= 2'h0;
          end
          else if (conv_end)
          begin
            state_r <= adcc_pkg::ADCC_IDLE;
            req_r   <= 1'b0;
            if (scan_mode_r && !pos_last)
            begin
              pos_r <= pos_r + 2'h1;
            end
            else
            begin
              pos_r <= 2'h0;
            end
          end
          else
          begin
            slot_r <= slot_r - 9'h001;
          end
        end
        default:
        begin
          state_r <= adcc_pkg::ADCC_IDLE;
          req_r   <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Result storage
  // ------------------------------------------------------------
  adcc_result_mem u_result_mem (
    .mclk    (mclk),
    .rstn    (rstn),
    .wr_en   (conv_end),
    .wr_idx  (res_idx),
    .wr_data (conv_data),
    .rd_en   (rd_res),
    .rd_idx  (rd_res_idx),
    .rd_data (mem_q)
  );

  // ------------------------------------------------------------
  // Interrupt request
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= conv_end_flag_r && conv_irq_enable_r;
    end
  end

  // ------------------------------------------------------------
  // Read path: strobe, then data two cycles later
  // ------------------------------------------------------------
  wire [7:0] csr_view = {conv_end_flag_r, conv_irq_enable_r, conv_go_r,
                         scan_mode_r, conv_speed_select_r, chan_sel_r};
  wire [7:0] trg_view = {timer_trigger_enable_r, adcc_pkg::TRG_LOW_ONES};
  wire [7:0] res_hi   = mem_q[9:2];
  wire [7:0] res_lo   = {mem_q[1:0], adcc_pkg::RES_LO_PAD};
  wire [7:0] rd_mux   = p1_res_hi ? res_hi :
                        p1_res_lo ? temp_r :
                        p1_csr    ? csr_view :
                        p1_trg    ? trg_view :
                                    adcc_pkg::RD_UNMAPPED;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_p1_r      <= 1'b0;
      rd_addr_p1_r <= 4'h0;
      rdata_r      <= 8'h00;
      rvalid_r     <= 1'b0;
      temp_r       <= 8'h00;
    end
    else
    begin
      rd_p1_r      <= bus_rd;
      rd_addr_p1_r <= bus_addr;
      rvalid_r     <= rd_p1_r;
      if (rd_p1_r)
      begin
        rdata_r <= rd_mux;
      end
      if (p1_res_hi)
      begin
        temp_r <= res_lo;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus_rdata    = rdata_r;
  assign bus_rvalid   = rvalid_r;
  assign conv_req     = req_r;
  assign conv_chan    = chan_r;
  assign conv_fast    = conv_speed_select_r;
  assign conv_end_irq = irq_r;

endmodule
`default_nettype wire

/* adcc_pkg.sv */
// Constants shared by the converter control and status logic
package adcc_pkg;

  // ------------------------------------------------------------
  // Register byte offsets on the 8-bit internal bus
  // ------------------------------------------------------------
  localparam logic [3:0] OFF_RES_A_HI = 4'h0;
  localparam logic [3:0] OFF_RES_A_LO = 4'h1;
  localparam logic [3:0] OFF_RES_B_HI = 4'h2;
  localparam logic [3:0] OFF_RES_B_LO = 4'h3;
  localparam logic [3:0] OFF_RES_C_HI = 4'h4;
  localparam logic [3:0] OFF_RES_C_LO = 4'h5;
  localparam logic [3:0] OFF_RES_D_HI = 4'h6;
  localparam logic [3:0] OFF_RES_D_LO = 4'h7;
  localparam logic [3:0] OFF_CSR      = 4'h8;
  localparam logic [3:0] OFF_TRG      = 4'h9;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned CSR_FLAG_BIT  = 7;
  localparam int unsigned CSR_IE_BIT    = 6;
  localparam int unsigned CSR_GO_BIT    = 5;
  localparam int unsigned CSR_SCAN_BIT  = 4;
  localparam int unsigned CSR_SPEED_BIT = 3;
  localparam int unsigned TRG_EN_BIT    = 7;

  // ------------------------------------------------------------
  // Values after reset and fixed read values
  // ------------------------------------------------------------
  localparam logic [7:0] CSR_RESET      = 8'h00;
  localparam logic [7:0] TRG_RESET      = 8'h7F;
  localparam logic [6:0] TRG_LOW_ONES   = 7'h7F;
  localparam logic [9:0] RES_RESET      = 10'h000;
  localparam logic [5:0] RES_LO_PAD     = 6'h00;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;

  // ------------------------------------------------------------
  // Conversion time limits, in states (one state is one mclk)
  // ------------------------------------------------------------
  localparam int unsigned CYC_PER_STATE     = 1;
  localparam int unsigned CONV_MAX_SLOW_ST  = 266;
  localparam int unsigned CONV_MAX_FAST_ST  = 134;
  localparam int unsigned CONV_MAX_SLOW_CYC = CONV_MAX_SLOW_ST * CYC_PER_STATE;
  localparam int unsigned CONV_MAX_FAST_CYC = CONV_MAX_FAST_ST * CYC_PER_STATE;
  localparam logic [8:0]  SLOT_SLOW_LOAD    = 9'(CONV_MAX_SLOW_CYC - 1);
  localparam logic [8:0]  SLOT_FAST_LOAD    = 9'(CONV_MAX_FAST_CYC - 1);

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [0:0] {ADCC_IDLE, ADCC_CONV} adcc_state_t;

endpackage

/* adcc_result_mem.sv */
// Four 10-bit conversion result registers with a registered read port
`timescale 1ns/10ps
`default_nettype none
module adcc_result_mem (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_idx,
  input  wire logic [9:0] wr_data,
  input  wire logic       rd_en,
  input  wire logic [1:0] rd_idx,
  output logic      [9:0] rd_data
);

  logic [9:0] mem_r [4];
  logic [9:0] rd_data_r;

  // ------------------------------------------------------------
  // Storage, cleared by power-on reset
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        mem_r[i] <= adcc_pkg::RES_RESET;
      end
    end
    else if (wr_en)
    begin
      mem_r[wr_idx] <= wr_data;
    end
  end

  // ------------------------------------------------------------
  // Read register; a same-cycle write is seen one read later
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data_r <= adcc_pkg::RES_RESET;
    end
    else if (rd_en)
    begin
      rd_data_r <= mem_r[rd_idx];
    end
  end

  assign rd_data = rd_data_r;

endmodule
`default_nettype wire

/* adcc_properties.sv */
// Port-level properties of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_properties (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       standby,
  input wire logic [3:0] bus_addr,
  input wire logic       bus_rd,
  input wire logic       bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic       bus_rvalid,
  input wire logic       multi_timer_unit_trig,
  input wire logic       conv_req,
  input wire logic [2:0] conv_chan,
  input wire logic       conv_fast,
  input wire logic       conv_done,
  input wire logic [9:0] conv_data,
  input wire logic       conv_end_irq
);
  localparam int SLOW = 266;
  localparam int FAST = 134;
  logic [8:0] slot_r;

  // ------------------------------------------------------------
  // Cycles of the current conversion slot
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      slot_r <= 9'h000;
    else if (conv_req)
      slot_r <= slot_r + 9'h001;
    else
      slot_r <= 9'h000;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence rd_trg;  bus_rd && bus_addr == adcc_pkg::OFF_TRG; endsequence
  sequence rd_lo;   bus_rd && !bus_addr[3] && bus_addr[0]; endsequence
  sequence rd_none; bus_rd && bus_addr > 4'h9; endsequence
  sequence core_end; conv_req && conv_done; endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_read_latency: assert property (bus_rd |-> ##2 bus_rvalid)
    else $error("read answer missing");
  a_rvalid_cause: assert property (bus_rvalid |-> $past(bus_rd, 2))
    else $error("read answer without strobe");
  a_trg_ones: assert property (rd_trg |-> ##2 bus_rdata[6:0] == 7'h7F)
    else $error("trigger low bits not ones");
  a_lo_pad: assert property (rd_lo |-> ##2 bus_rdata[5:0] == 6'h00)
    else $error("low byte pad not zero");
  a_unmapped_zero: assert property (rd_none |-> ##2 bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_done_ends: assert property (core_end |=> !conv_req)
    else $error("request not dropped after done");
  a_chan_stable: assert property (conv_req && $past(conv_req) |-> $stable(conv_chan))
    else $error("channel moved during request");
  a_slot_bound: assert property (conv_req |-> slot_r < (conv_fast ? FAST : SLOW))
    else $error("conversion slot too long");
  a_irq_cause: assert property ($rose(conv_end_irq) |->
    ($past(conv_req, 2) && !$past(conv_req)) || $past(bus_wr) || $past(bus_wr, 2))
    else $error("request rose without cause");
  a_irq_drop: assert property ($fell(conv_end_irq) |-> $past(bus_wr) || $past(bus_wr, 2))
    else $error("request fell without write");
endmodule

bind adcc_top adcc_properties i_adcc_properties (
  .mclk(mclk), .rstn(rstn), .standby(standby), .bus_addr(bus_addr),
  .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .bus_rvalid(bus_rvalid), .multi_timer_unit_trig(multi_timer_unit_trig),
  .conv_req(conv_req), .conv_chan(conv_chan), .conv_fast(conv_fast),
  .conv_done(conv_done), .conv_data(conv_data), .conv_end_irq(conv_end_irq)
);
`default_nettype wire

/* adcc_core_model.sv */
// Behavioural analog conversion core on the request/done handshake
`timescale 1ns/10ps
`default_nettype none
module adcc_core_model (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       conv_req,
  input  wire logic [2:0] conv_chan,
  input  wire logic [9:0] base,
  input  wire logic [8:0] dly,
  output logic            conv_done,
  output logic      [9:0] conv_data
);
  logic [8:0] cnt_r;
  logic [9:0] res;

  assign res = base ^ {7'h00, conv_chan};
  // Data shows the inverse outside the done pulse
  assign conv_data = conv_done ? res : ~res;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= 9'h000;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      cnt_r <= 9'h000;
      if (conv_req && !conv_done && cnt_r == dly)
        conv_done <= 1'b1;
      else if (conv_req && !conv_done)
        cnt_r <= cnt_r + 9'h001;
    end
  end
endmodule
`default_nettype wire

/* adcc_top_bench.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcc_top_bench;
  logic       mclk, rstn, standby, bus_rd, bus_wr, bus_rvalid, trig;
  logic       conv_req, conv_fast, conv_done, conv_end_irq, ie, spd;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, d;
  logic [2:0] conv_chan, code;
  logic [9:0] conv_data, base, r;
  logic [8:0] dly;
  int         num_errors, total_checks, p;

  always #4 mclk = ~mclk;

  adcc_top i_adcc_top (
    .mclk(mclk), .rstn(rstn), .standby(standby), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .multi_timer_unit_trig(trig), .conv_req(conv_req),
    .conv_chan(conv_chan), .conv_fast(conv_fast), .conv_done(conv_done),
    .conv_data(conv_data), .conv_end_irq(conv_end_irq)
  );
  adcc_core_model i_adcc_core_model (
    .mclk(mclk), .rstn(rstn), .conv_req(conv_req), .conv_chan(conv_chan),
    .base(base), .dly(dly), .conv_done(conv_done), .conv_data(conv_data)
  );

  // ------------------------------------------------------------
  // Expectations and bus tasks
  // ------------------------------------------------------------
  function automatic logic [9:0] res_of(input logic [9:0] b, input logic [2:0] c);
    return b ^ {7'h00, c};
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge mclk);
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(negedge mclk);
    bus_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    int i;
    @(negedge mclk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge mclk);
    bus_rd = 1'b0;
    for (i = 0; i < 4 && bus_rvalid !== 1'b1; i++)
      @(negedge mclk);
    chk("rvalid", {7'h00, bus_rvalid}, 8'h01);
    v = bus_rdata;
  endtask

  // Bounded wait: sel 0 waits on the request line to the CPU, 1 on the core request
  task automatic wait_for(input int sel, input logic v);
    int i;
    for (i = 0; i < 600 && (sel == 0 ? conv_end_irq : conv_req) !== v; i++)
      @(negedge mclk);
    if (i == 600)
    begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic chk_res(input logic [2:0] c, input logic [1:0] idx);
    r = res_of(base, c);
    rd({1'b0, idx, 1'b0}, d);
    chk("res_hi", d, r[9:2]);
    rd({1'b0, idx, 1'b1}, d);
    chk("res_lo", d, {r[1:0], 6'h00});
  endtask

  task automatic pulse_trig();
    @(negedge mclk);
    trig = 1'b1;
    repeat (2) @(negedge mclk);
    trig = 1'b0;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    {standby, bus_rd, bus_wr, trig} = 4'h0;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    base = 10'h000;
    dly = 9'h000;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(43));
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    rd(adcc_pkg::OFF_CSR, d);
    chk("csr_reset", d, adcc_pkg::CSR_RESET);
    rd(adcc_pkg::OFF_TRG, d);
    chk("trg_reset", d, adcc_pkg::TRG_RESET);
    rd(4'hC, d);
    chk("unmapped", d, 8'h00);
    $display("test reset done");

    for (int c = 0; c < 7; c++)
    begin
      base = 10'($urandom);
      dly = 9'($urandom % 20);
      spd = 1'($urandom);
      ie = (c != 3);
      wr(adcc_pkg::OFF_CSR, {1'b0, ie, 1'b1, 1'b0, spd, 3'(c)});
      wait_for(1, 1'b1);
      chk("chan", {5'h00, conv_chan}, 8'(c));
      chk("fast", {7'h00, conv_fast}, {7'h00, spd});
      wait_for(1, 1'b0);
      repeat (3) @(negedge mclk);
      chk("irq", {7'h00, conv_end_irq}, {7'h00, ie});
      rd(adcc_pkg::OFF_CSR, d);
      chk("csr_end", d, {1'b1, ie, 2'b00, spd, 3'(c)});
      wr(adcc_pkg::OFF_CSR, 8'h80);
      rd(adcc_pkg::OFF_CSR, d);
      chk("flag_w1", d, 8'h80);
      wr(adcc_pkg::OFF_CSR, 8'h00);
      rd(adcc_pkg::OFF_CSR, d);
      chk("flag_clr", d, 8'h00);
      wr(adcc_pkg::OFF_CSR, 8'h80);
      rd(adcc_pkg::OFF_CSR, d);
      chk("flag_w1_idle", d, 8'h00);
      chk("irq_clr", {7'h00, conv_end_irq}, 8'h00);
      chk_res(3'(c), 2'(c % 4));
    end
    $display("test single done");

    for (int k = 0; k < 2; k++)
    begin
      code = k ? 3'h6 : 3'h2;
      base = 10'($urandom);
      dly = 9'($urandom % 10);
      wr(adcc_pkg::OFF_CSR, {5'h0E, code});
      wait_for(0, 1'b1);
      rd(adcc_pkg::OFF_CSR, d);
      chk("scan_csr", d, {5'h1E, code});
      wr(adcc_pkg::OFF_CSR, {5'h02, code});
      wait_for(1, 1'b0);
      repeat (4) @(negedge mclk);
      chk("scan_stop", {7'h00, conv_req}, 8'h00);
      for (p = 0; p < 3; p++)
        chk_res({code[2], 2'(p)}, 2'(p));
    end
    r = res_of(base, 3'h4);
    rd(4'h0, d);
    rd(4'h3, d);
    chk("stale_lo", d, {r[1:0], 6'h00});
    $display("test scan done");

    wr(adcc_pkg::OFF_TRG, 8'h00);
    rd(adcc_pkg::OFF_TRG, d);
    chk("trg_ro", d, 8'h7F);
    wr(adcc_pkg::OFF_CSR, 8'h45);
    pulse_trig();
    repeat (5) @(negedge mclk);
    chk("trg_off", {7'h00, conv_req}, 8'h00);
    wr(adcc_pkg::OFF_TRG, 8'hFF);
    rd(adcc_pkg::OFF_TRG, d);
    chk("trg_on", d, 8'hFF);
    dly = 9'd60;
    pulse_trig();
    wait_for(1, 1'b1);
    rd(adcc_pkg::OFF_CSR, d);
    chk("go_busy", d, 8'h65);
    wait_for(0, 1'b1);
    wr(adcc_pkg::OFF_CSR, 8'h45);
    rd(adcc_pkg::OFF_CSR, d);
    chk("no_read_clr", d, 8'hC5);
    @(negedge mclk);
    standby = 1'b1;
    @(negedge mclk);
    standby = 1'b0;
    rd(adcc_pkg::OFF_TRG, d);
    chk("standby", d, adcc_pkg::TRG_RESET);
    $display("test trigger done");

    wr(adcc_pkg::OFF_CSR, 8'h00);
    dly = 9'd300;
    wr(adcc_pkg::OFF_CSR, 8'h28);
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    repeat (2) @(negedge mclk);
    rd(adcc_pkg::OFF_CSR, d);
    chk("timeout", d, 8'h88);
    $display("test timeout done");
    print_verdict();
  end
endmodule
`default_nettype wire
